//--- common/bsh_pkg.sv
// shared types and constants for the bridge status and handshake block
package bsh_pkg;

    // register port map, word addresses
    localparam logic [3:0] BSH_ADDR_STATUS  = 4'h0;
    localparam logic [3:0] BSH_ADDR_CONTROL = 4'h1;
    localparam logic [3:0] BSH_ADDR_COUNT   = 4'h2;
    localparam logic [3:0] BSH_ADDR_PHASE   = 4'h3;

    // control register fields and reset value
    localparam int         BSH_CTL_HOST256_BIT = 0;
    localparam logic [7:0] BSH_CTL_RESET       = 8'h00;

    // timing at 40 MHz
    localparam int BSH_CLK_MHZ          = 40;
    localparam int BSH_SELFTEST_US      = 10;
    localparam int BSH_SELFTEST_CYCLES  = BSH_SELFTEST_US * BSH_CLK_MHZ;
    localparam int BSH_BANK_SWITCH_NS   = 500;
    localparam int BSH_BANK_SWITCH_CYC  = (BSH_BANK_SWITCH_NS * BSH_CLK_MHZ + 999) / 1000;

    // slave population limits
    localparam logic [8:0] BSH_SLAVES_LOW_MAX = 9'h080;
    localparam logic [7:0] BSH_BANK_HIGH_BASE = 8'h80;

    // status flags towards the host
    typedef struct packed {
        logic link_ready;
        logic line_short_error;
        logic supply_drop_error;
        logic line_break_error;
        logic overcount_error;
        logic handshake_capable;
        logic param_busy;
        logic adjust_active;
        logic slave_alarm;
        logic param_done;
        logic param_error;
        logic addr_scan_active;
        logic bank_shown;
        logic bank_switching;
    } bsh_status_t;

    // command bits from the host
    typedef struct packed {
        logic error_clear_req;
        logic param_access_cmd;
        logic param_read_all_cmd;
        logic param_write_all_cmd;
        logic bank_select;
        logic bank_switch_cmd;
    } bsh_cmd_t;

    // fault and activity inputs from the bridge internals
    typedef struct packed {
        logic hw_fault;
        logic pair_short;
        logic over_current;
        logic supply_low;
        logic pair_break;
        logic slave_lost;
        logic slave_status_fault;
        logic slave_addr_fault;
        logic scan_start;
        logic scan_done;
        logic adjust_mode;
        logic display_present;
    } bsh_event_t;

    typedef enum logic [2:0] {
        BSH_P_IDLE = 3'b001,
        BSH_P_PROC = 3'b010,
        BSH_P_WAIT = 3'b100
    } bsh_param_state_t;

    typedef enum logic [2:0] {
        BSH_B_IDLE = 3'b001,
        BSH_B_SWAP = 3'b010,
        BSH_B_WAIT = 3'b100
    } bsh_bank_state_t;

endpackage : bsh_pkg

//--- design/bsh_flags.sv
// status flags and handshakes of the bridge cyclic bit interface
// Notes on behaviour
// - ready after power-up and self test
// - ready drops on hardware failure
// - short or overcurrent sets sticky error
// - sticky errors clear on clear-request falling edge
// - supply drop sets sticky error
// - line break or lost slave sets sticky
// - overcount when 129+ slaves, host limited
// - overcount clears on rescan or power cycle
// - handshake capable held high
// - busy set when parameter processing starts
// - busy clears when done and commands low
// - done asserted when parameter access finishes
// - parameter failure sets sticky error
// - adjust active during adjustment mode, detection masked
// - adjust clears on normal mode or unplug
// - slave fault sets sticky alarm
// - scan active from detection start to end
// - bank shown low 1-128, high 129-256
// - bank selects remote word contents
// - switching set on command rising edge
// - switching clears after swap and command low
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps

module bsh_flags #(
    parameter int SELFTEST_CYCLES = bsh_pkg::BSH_SELFTEST_CYCLES,
    parameter int BANK_CYCLES     = bsh_pkg::BSH_BANK_SWITCH_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire bsh_pkg::bsh_cmd_t    host_cmd,
    input  wire bsh_pkg::bsh_event_t  events,
    input  wire logic [8:0]           slave_count,
    input  wire logic                 param_finish,
    input  wire logic                 param_fail,
    output bsh_pkg::bsh_status_t      status,
    output logic                      param_start,
    output logic [1:0]                param_kind,
    output logic [7:0]                bank_module_base,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [15:0]               reg_rdata
);
    import bsh_pkg::*;

    // counters are 16 and 8 bits wide, so larger counts cannot be served
    if (SELFTEST_CYCLES < 1 || SELFTEST_CYCLES > 65535) begin : g_bad_selftest
        $error("SELFTEST_CYCLES out of range");
    end
    if (BANK_CYCLES < 1 || BANK_CYCLES > 255) begin : g_bad_bank
        $error("BANK_CYCLES out of range");
    end

    bsh_param_state_t param_state;
    bsh_bank_state_t  bank_state;
    logic [15:0]      test_count;
    logic             test_done;
    logic             clear_prev;
    logic             clear_pulse;
    logic             bank_cmd_prev;
    logic             bank_cmd_rise;
    logic [7:0]       bank_count;
    logic             bank_target;
    logic [7:0]       control;
    logic             any_param_cmd;
    logic             host256;
    logic [15:0]      status_word;

    assign host256       = control[BSH_CTL_HOST256_BIT];
    assign any_param_cmd = host_cmd.param_access_cmd | host_cmd.param_read_all_cmd | host_cmd.param_write_all_cmd;
    // clear acts on the on-then-off pulse, i.e. the falling edge
    assign clear_pulse   = clear_prev & ~host_cmd.error_clear_req;
    assign bank_cmd_rise = host_cmd.bank_switch_cmd & ~bank_cmd_prev;
    assign bank_module_base = status.bank_shown ? BSH_BANK_HIGH_BASE : 8'h00;

    // edge history
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clear_prev    <= 1'b0;
            bank_cmd_prev <= 1'b0;
        end else begin
            clear_prev    <= host_cmd.error_clear_req;
            bank_cmd_prev <= host_cmd.bank_switch_cmd;
        end
    end

    // self test after reset, then ready
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            test_count <= 16'h0000;
            test_done  <= 1'b0;
        end else if (!test_done) begin
            test_count <= test_count + 16'h0001;
            test_done  <= (test_count == 16'(SELFTEST_CYCLES - 1));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status.link_ready <= 1'b0;
        end else begin
            status.link_ready <= test_done & ~events.hw_fault;
        end
    end

    // sticky errors: a live cause wins over a clear pulse
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status.line_short_error  <= 1'b0;
            status.supply_drop_error <= 1'b0;
            status.line_break_error  <= 1'b0;
            status.slave_alarm       <= 1'b0;
        end else begin
            status.line_short_error  <= events.pair_short | events.over_current
                                        | (status.line_short_error & ~clear_pulse);
            status.supply_drop_error <= events.supply_low
                                        | (status.supply_drop_error & ~clear_pulse);
            // slave loss cannot be seen while the display unit adjusts
            status.line_break_error  <= events.pair_break | (events.slave_lost & ~status.adjust_active)
                                        | (status.line_break_error & ~clear_pulse);
            status.slave_alarm       <= events.slave_status_fault | events.slave_addr_fault
                                        | (status.slave_alarm & ~clear_pulse);
        end
    end

    // overcount judged at the end of each address scan; reset is the power cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status.overcount_error <= 1'b0;
        end else if (events.scan_done) begin
            status.overcount_error <= (slave_count > BSH_SLAVES_LOW_MAX) & ~host256;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status.addr_scan_active <= 1'b0;
        end else if (events.scan_start) begin
            status.addr_scan_active <= 1'b1;
        end else if (events.scan_done) begin
            status.addr_scan_active <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status.adjust_active <= 1'b0;
        end else begin
            status.adjust_active <= events.adjust_mode & events.display_present;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status.handshake_capable <= 1'b0;
        end else begin
            status.handshake_capable <= 1'b1;
        end
    end

    // parameter handshake
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            param_state       <= BSH_P_IDLE;
            status.param_busy <= 1'b0;
            status.param_done <= 1'b0;
            param_start       <= 1'b0;
            param_kind        <= 2'b00;
        end else begin
            param_start <= 1'b0;
            unique case (param_state)
                BSH_P_IDLE: begin
                    // requests are not seen during adjustment mode
                    if (any_param_cmd && !status.adjust_active) begin
                        param_state       <= BSH_P_PROC;
                        status.param_busy <= 1'b1;
                        status.param_done <= 1'b0;
                        param_start       <= 1'b1;
                        // access command has priority if the host raises several
                        param_kind        <= host_cmd.param_access_cmd   ? 2'b00 :
                                             host_cmd.param_read_all_cmd ? 2'b01 : 2'b10;
                    end
                end
                BSH_P_PROC: begin
                    if (param_finish || param_fail) begin
                        param_state       <= BSH_P_WAIT;
                        status.param_done <= 1'b1;
                    end
                end
                BSH_P_WAIT: begin
                    if (!any_param_cmd) begin
                        param_state       <= BSH_P_IDLE;
                        status.param_busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status.param_error <= 1'b0;
        end else begin
            status.param_error <= (param_state == BSH_P_PROC && param_fail)
                                  | (status.param_error & ~clear_pulse);
        end
    end

    // bank switching handshake; select is sampled at the command edge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bank_state            <= BSH_B_IDLE;
            status.bank_switching <= 1'b0;
            status.bank_shown     <= 1'b0;
            bank_target           <= 1'b0;
            bank_count            <= 8'h00;
        end else begin
            unique case (bank_state)
                BSH_B_IDLE: begin
                    if (bank_cmd_rise) begin
                        bank_state            <= BSH_B_SWAP;
                        status.bank_switching <= 1'b1;
                        bank_target           <= host_cmd.bank_select;
                        bank_count            <= 8'h00;
                    end
                end
                BSH_B_SWAP: begin
                    bank_count <= bank_count + 8'h01;
                    if (bank_count == 8'(BANK_CYCLES - 1)) begin
                        bank_state        <= BSH_B_WAIT;
                        status.bank_shown <= bank_target;
                    end
                end
                BSH_B_WAIT: begin
                    if (!host_cmd.bank_switch_cmd) begin
                        bank_state            <= BSH_B_IDLE;
                        status.bank_switching <= 1'b0;
                    end
                end
            endcase
        end
    end

    // register port
    assign status_word = {2'b00, status};

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            control <= BSH_CTL_RESET;
        end else if (reg_wr && reg_addr == BSH_ADDR_CONTROL) begin
            control <= reg_wdata[7:0];
        end
    end

    // unmapped or idle reads return zero
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                BSH_ADDR_STATUS:  reg_rdata <= status_word;
                BSH_ADDR_CONTROL: reg_rdata <= {8'h00, control};
                BSH_ADDR_COUNT:   reg_rdata <= {7'h00, slave_count};
                BSH_ADDR_PHASE:   reg_rdata <= {10'h000, bank_state, param_state};
                default:          reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule : bsh_flags

//--- tb/bsh_flags_monitor.sv
// concurrent checks on the status and handshake ports
`timescale 1ns/100ps
module bsh_flags_monitor #(
    parameter int SELFTEST_CYCLES = bsh_pkg::BSH_SELFTEST_CYCLES,
    parameter int BANK_CYCLES     = bsh_pkg::BSH_BANK_SWITCH_CYC
) (
    input wire logic                 core_clk,
    input wire logic                 reset_n,
    input wire bsh_pkg::bsh_cmd_t    host_cmd,
    input wire bsh_pkg::bsh_event_t  events,
    input wire logic                 param_finish,
    input wire logic                 param_fail,
    input wire bsh_pkg::bsh_status_t status,
    input wire logic                 param_start,
    input wire logic [7:0]           bank_module_base
);
    import bsh_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic short_cause;
    assign short_cause = events.pair_short || events.over_current;
    sequence s_clear_fall;
        host_cmd.error_clear_req ##1 !host_cmd.error_clear_req;
    endsequence
    sequence s_bank_rise;
        !host_cmd.bank_switch_cmd ##1 host_cmd.bank_switch_cmd && !status.bank_switching;
    endsequence
    chk_capable_high: assert property ($past(reset_n) |-> status.handshake_capable)
        else $error("capable flag low");
    chk_ready_fault: assert property (events.hw_fault |=> !status.link_ready)
        else $error("ready kept on fault");
    chk_short_sets: assert property (short_cause |=> status.line_short_error)
        else $error("short flag not set");
    chk_sticky_hold: assert property (status.line_short_error && !$fell(host_cmd.error_clear_req)
        |=> status.line_short_error)
        else $error("short flag dropped");
    chk_clear_works: assert property (s_clear_fall ##0 !short_cause |=> !status.line_short_error)
        else $error("clear pulse ignored");
    chk_scan_track: assert property (events.scan_start || events.scan_done
        |=> status.addr_scan_active == $past(events.scan_start))
        else $error("scan flag wrong");
    chk_adjust_follow: assert property ($past(reset_n)
        |-> status.adjust_active == $past(events.adjust_mode && events.display_present))
        else $error("adjust flag wrong");
    chk_start_busy: assert property (param_start |-> status.param_busy && !status.param_done)
        else $error("start without busy");
    chk_busy_hold: assert property (status.param_busy && (host_cmd[4:2] != 3'b000) |=> status.param_busy)
        else $error("busy dropped early");
    chk_finish_done: assert property ((param_finish || param_fail) && status.param_busy && !status.param_done
        |=> status.param_done && (status.param_error || !$past(param_fail)))
        else $error("finish not flagged");
    chk_bank_rise: assert property (s_bank_rise |=> status.bank_switching)
        else $error("switch not started");
    chk_switch_hold: assert property (status.bank_switching && host_cmd.bank_switch_cmd
        |=> status.bank_switching)
        else $error("switch ended early");
    chk_shown_gated: assert property ($changed(status.bank_shown) |-> $past(status.bank_switching))
        else $error("bank moved while idle");
    chk_base_follow: assert property (bank_module_base
        == (status.bank_shown ? BSH_BANK_HIGH_BASE : 8'h00))
        else $error("bank base wrong");
endmodule : bsh_flags_monitor
bind bsh_flags bsh_flags_monitor #(.SELFTEST_CYCLES(SELFTEST_CYCLES), .BANK_CYCLES(BANK_CYCLES)) i_mon (
    .core_clk(core_clk), .reset_n(reset_n), .host_cmd(host_cmd), .events(events),
    .param_finish(param_finish), .param_fail(param_fail), .status(status),
    .param_start(param_start), .bank_module_base(bank_module_base));

//--- tb/bsh_host_model.sv
// host side model driving the command bits
`timescale 1ns/100ps
module bsh_host_model (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire bsh_pkg::bsh_status_t status,
    input  wire logic [2:0]           go_param,
    input  wire logic                 go_bank,
    input  wire logic                 bank_sel,
    input  wire logic                 go_clear,
    input  wire logic                 slow,
    output bsh_pkg::bsh_cmd_t         host_cmd
);
    import bsh_pkg::*;
    logic [1:0] clr_cnt;
    always @(posedge core_clk) begin
        if (!reset_n) begin
            host_cmd <= '0;
            clr_cnt  <= 2'h0;
        end else begin
            // bits 4:2 are the three parameter commands, one at a time
            if (go_param != 3'b000 && !status.param_busy)
                host_cmd[4:2] <= go_param;
            else if (status.param_busy && status.param_done && !slow)
                host_cmd[4:2] <= 3'b000;
            if (go_bank) begin
                host_cmd.bank_select     <= bank_sel;
                host_cmd.bank_switch_cmd <= 1'b1;
            end else if (status.bank_switching && !slow)
                host_cmd.bank_switch_cmd <= 1'b0;
            if (go_clear) begin
                host_cmd.error_clear_req <= 1'b1;
                clr_cnt                  <= 2'h2;
            end else if (clr_cnt != 2'h0) begin
                clr_cnt <= clr_cnt - 2'h1;
                if (clr_cnt == 2'h1)
                    host_cmd.error_clear_req <= 1'b0;
            end
        end
    end
endmodule : bsh_host_model

//--- tb/tb_top.sv
// self-checking bench for the status and handshake block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import bsh_pkg::*;
    localparam int ST = 4;
    localparam int BK = 2;
    logic        core_clk     = 1'b0;
    logic        reset_n      = 1'b0;
    bsh_event_t  events       = '0;
    logic [8:0]  slave_count  = 9'h000;
    logic        param_finish = 1'b0;
    logic        param_fail   = 1'b0;
    logic [3:0]  reg_addr     = 4'h0;
    logic [15:0] reg_wdata    = 16'h0000;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic [2:0]  go_param     = 3'b000;
    logic        go_bank      = 1'b0;
    logic        bank_sel     = 1'b0;
    logic        go_clear     = 1'b0;
    logic        slow         = 1'b0;
    bsh_cmd_t    host_cmd;
    bsh_status_t status;
    logic        param_start;
    logic [1:0]  param_kind;
    logic [7:0]  bank_module_base;
    logic [15:0] reg_rdata;
    int          n_errors     = 0;
    int          n_tests      = 0;
    int          cycles       = 0;
    int          cause[7]     = '{10, 9, 8, 7, 6, 5, 4};
    int          flag[7]      = '{12, 12, 11, 10, 10, 5, 5};
    logic [8:0]  cnt_tab[4]   = '{9'h081, 9'h080, 9'h100, 9'h081};
    logic        ctl_tab[4]   = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic        exp_tab[4]   = '{1'b1, 1'b0, 1'b0, 1'b1};
    bsh_flags #(.SELFTEST_CYCLES(ST), .BANK_CYCLES(BK)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .host_cmd(host_cmd), .events(events),
        .slave_count(slave_count), .param_finish(param_finish), .param_fail(param_fail),
        .status(status), .param_start(param_start), .param_kind(param_kind),
        .bank_module_base(bank_module_base), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    bsh_host_model i_host (
        .core_clk(core_clk), .reset_n(reset_n), .status(status), .go_param(go_param),
        .go_bank(go_bank), .bank_sel(bank_sel), .go_clear(go_clear), .slow(slow), .host_cmd(host_cmd));
    always #12.5 core_clk = ~core_clk;
    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // limit well above the few hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic do_reset();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
    endtask : do_reset
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write
    task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : reg_chk
    task automatic wait_st(input int b, input logic v);
        #1;
        for (int i = 0; i < 64 && status[b] !== v; i++)
            cyc(1);
        `CHK(status[b], v)
    endtask : wait_st
    task automatic pulse_ev(input int b);
        @(posedge core_clk);
        events[b] <= 1'b1;
        @(posedge core_clk);
        events[b] <= 1'b0;
        #1;
    endtask : pulse_ev
    task automatic kick(input logic [2:0] p, input logic b, input logic c);
        @(posedge core_clk);
        go_param <= p;
        go_bank  <= b;
        go_clear <= c;
        @(posedge core_clk);
        go_param <= 3'b000;
        go_bank  <= 1'b0;
        go_clear <= 1'b0;
    endtask : kick
    initial begin
        do_reset();
        `CHK(status, 14'h0000)
        cyc(1);
        `CHK(status.link_ready, 1'b0)
        cyc(ST + 2);
        `CHK(status, 14'h2100)
        reg_chk(BSH_ADDR_CONTROL, {8'h00, BSH_CTL_RESET});
        reg_write(BSH_ADDR_CONTROL, 16'h0001);
        reg_chk(BSH_ADDR_CONTROL, 16'h0001);
        reg_write(BSH_ADDR_STATUS, 16'hffff);
        reg_chk(BSH_ADDR_STATUS, 16'h2100);
        reg_chk(BSH_ADDR_PHASE, 16'h0009);
        reg_chk(4'hf, 16'h0000);
        @(posedge core_clk);
        events.hw_fault <= 1'b1;
        cyc(2);
        `CHK(status.link_ready, 1'b0)
        @(posedge core_clk);
        events.hw_fault <= 1'b0;
        cyc(2);
        `CHK(status.link_ready, 1'b1)
        foreach (cause[k]) begin
            @(posedge core_clk);
            events[cause[k]] <= 1'b1;
            cyc(2);
            kick(3'b000, 1'b0, 1'b1);
            cyc(6);
            `CHK(status[flag[k]], 1'b1)
            @(posedge core_clk);
            events[cause[k]] <= 1'b0;
            cyc(4);
            `CHK(status[flag[k]], 1'b1)
            kick(3'b000, 1'b0, 1'b1);
            cyc(6);
            `CHK(status[flag[k]], 1'b0)
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            events[1:0] <= 2'b11;
            cyc(1);
            @(posedge core_clk);
            events.slave_lost <= 1'b1;
            cyc(2);
            `CHK(status.adjust_active, 1'b1)
            `CHK(status.line_break_error, 1'b0)
            @(posedge core_clk);
            events.slave_lost <= 1'b0;
            events[1:0]       <= k ? 2'b01 : 2'b10;
            cyc(2);
            `CHK(status.adjust_active, 1'b0)
        end
        foreach (cnt_tab[k]) begin
            reg_write(BSH_ADDR_CONTROL, {15'h0000, ctl_tab[k]});
            slave_count <= cnt_tab[k];
            pulse_ev(3);
            `CHK(status.addr_scan_active, 1'b1)
            pulse_ev(2);
            `CHK(status.addr_scan_active, 1'b0)
            `CHK(status.overcount_error, exp_tab[k])
            reg_chk(BSH_ADDR_COUNT, {7'h00, cnt_tab[k]});
        end
        do_reset();
        cyc(ST + 3);
        `CHK(status.overcount_error, 1'b0)
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            slow <= (k == 0);
            kick(3'b100 >> k, 1'b0, 1'b0);
            wait_st(7, 1'b1);
            `CHK(param_start, 1'b1)
            `CHK(param_kind, k[1:0])
            `CHK(status.param_done, 1'b0)
            @(posedge core_clk);
            param_finish <= (k != 2);
            param_fail   <= (k == 2);
            @(posedge core_clk);
            param_finish <= 1'b0;
            param_fail   <= 1'b0;
            cyc(3);
            `CHK(status.param_done, 1'b1)
            `CHK(status.param_error, k == 2)
            `CHK(status.param_busy, k == 0)
            @(posedge core_clk);
            slow <= 1'b0;
            wait_st(7, 1'b0);
        end
        kick(3'b000, 1'b0, 1'b1);
        cyc(6);
        `CHK(status.param_error, 1'b0)
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            slow     <= 1'b1;
            bank_sel <= (k == 0);
            kick(3'b000, 1'b1, 1'b0);
            wait_st(0, 1'b1);
            cyc(BK + 2);
            `CHK(status.bank_shown, k == 0)
            `CHK(bank_module_base, (k == 0) ? BSH_BANK_HIGH_BASE : 8'h00)
            `CHK(status.bank_switching, 1'b1)
            @(posedge core_clk);
            slow <= 1'b0;
            wait_st(0, 1'b0);
        end
        tally_and_finish();
    end
endmodule : tb_top
